/* File: hdl/tdsp_pkg.sv */
/*
  Shared constants and types for the timer-driven asynchronous serial port.
  Assumes a single 100 MHz clock that also stands in for the crystal.
*/
package tdsp_pkg;
  // Time base: the bit time counter advances once per TICK_DIV * PRESCALE clocks.
  localparam int CRYSTAL_HZ = 100_000_000;
  localparam int BAUD = 9600;
  localparam int PRESCALE = 1;
  localparam int TICK_DIV = 4;
  localparam int TICK_CYCLES = TICK_DIV * PRESCALE;
  localparam logic [15:0] BIT_INC_RST = 16'(CRYSTAL_HZ / (TICK_DIV * BAUD * PRESCALE));
  localparam logic [15:0] SAMPLE_RST = 16'h0064;
  // Frame shape.
  localparam int DATA_BITS = 7;
  localparam int MAX_SHIFT = 16;
  localparam logic [4:0] SHIFT_CYCLES = 5'h09;
  localparam int MSG_BYTES = 4;
  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TXDATA = 8'h08;
  localparam logic [7:0] ADDR_RXDATA = 8'h0C;
  localparam logic [7:0] ADDR_TIMING = 8'h10;
  // Field positions.
  localparam int CTRL_GO = 0;
  localparam int CTRL_RXEN = 1;
  localparam int CTRL_MAJ = 2;
  localparam int ST_TXBUSY = 0;
  localparam int ST_RXBUSY = 1;
  localparam int ST_PERR = 2;
  localparam int ST_FERR = 3;
  localparam int ST_RXDONE = 4;
  localparam int ST_RXCNT = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    TX_IDLE = 2'h0,
    TX_SHIFT = 2'h1,
    TX_DONE = 2'h3
  } tdsp_tx_state_t;

  typedef enum logic [1:0] {
    RX_CAPTURE = 2'h0,
    RX_COMPARE = 2'h1,
    RX_MAJ2 = 2'h3,
    RX_MAJ3 = 2'h2
  } tdsp_rx_state_t;

  typedef struct packed {
    logic rx_en;
    logic majority;
    logic [15:0] bit_inc;
    logic [15:0] sample_interval;
  } tdsp_cfg_t;
endpackage

/* File: hdl/tdsp_top.sv */
/*
  Timer-driven asynchronous serial port with an AXI4-Lite register slave.
  Assumes rx_pin_in arrives from a line driver, asynchronous to clk_in.
*/
// Design decisions made here: the address map and register access over AXI4-Lite.
// Notes on behaviour
// RL1 - Frame is start bit, 7 data bits, parity, stop: ten bit periods.
// RL2 - Link runs at 9600 bit/s with odd parity over data and parity.
// RL3 - Transmitter drives pin low as start bit before any data bit.
// RL4 - Transmit compare increment is crystal over four times baud times prescale.
// RL5 - Each transmit compare match shifts the next bit onto the pin.
// RL6 - Shifter sends 7 data bits, parity, then a high stop bit.
// RL7 - Transmit shifter holds at most 16 bits per transfer.
// RL8 - One character takes 9 shift cycles plus one completion event.
// RL9 - Transmit data is right-justified and sent least significant bit first.
// RL10 - Completion event follows the stop bit on the transmit compare channel.
// RL11 - After completion: load byte, count 9, start bit, first bit one period later.
// RL12 - Transmit sends a 4-byte message, reloading between bytes.
// RL13 - Idle receiver captures falling edges; a start edge begins reception.
// RL14 - Start edge switches to compare mode, first compare 1.5 bit periods later.
// RL15 - Each receive cycle samples the pin and shifts it in, one period apart.
// RL16 - Majority mode takes a second sample, and a deciding third on disagreement.
// RL17 - Spacing between majority samples comes from a programmable sample interval.
// RL18 - One received character takes nine sample cycles and two events.
// RL19 - Channel mode tells start edge (capture) from completion (compare).
// RL20 - On completion check parity and framing, then store the word.
// RL21 - After storing, the receive channel returns to falling-edge capture.
// RL22 - Receiver accepts a 4-byte message, rearming after each character.
// RL23 - Transmit line idles high between characters.
`timescale 1ns/1ps
module tdsp_top (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic reset_in,
  // AXI4-Lite write address and data.
  input wire logic axi_awvalid_in,
  output logic axi_awready_out,
  input wire logic [7:0] axi_awaddr_in,
  input wire logic axi_wvalid_in,
  output logic axi_wready_out,
  input wire logic [31:0] axi_wdata_in,
  input wire logic [3:0] axi_wstrb_in,
  // AXI4-Lite write response.
  output logic axi_bvalid_out,
  input wire logic axi_bready_in,
  output logic [1:0] axi_bresp_out,
  // AXI4-Lite read.
  input wire logic axi_arvalid_in,
  output logic axi_arready_out,
  input wire logic [7:0] axi_araddr_in,
  output logic axi_rvalid_out,
  input wire logic axi_rready_in,
  output logic [31:0] axi_rdata_out,
  output logic [1:0] axi_rresp_out,
  // Serial pins.
  input wire logic rx_pin_in,
  output logic tx_pin_out
);
  tdsp_pkg::tdsp_cfg_t cfg_q;
  tdsp_pkg::tdsp_tx_state_t tx_state_q;
  tdsp_pkg::tdsp_rx_state_t rx_state_q;
  logic [31:0] txdata_q;
  logic [31:0] rxdata_q;
  logic [2:0] presc_q;
  logic tick;
  logic [15:0] timer_q;
  logic aw_hold_q;
  logic w_hold_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_en;
  logic wr_hit;
  logic [31:0] wmask;
  logic go;

  // Bit time counter: one tick every TICK_CYCLES clocks. // RL4
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      presc_q <= 3'h0;
      timer_q <= 16'h0000;
    end else begin
      presc_q <= tick ? 3'h0 : presc_q + 3'h1;
      if (tick) begin
        timer_q <= timer_q + 16'h0001;
      end
    end
  end
  assign tick = (presc_q == 3'(tdsp_pkg::TICK_CYCLES - 1));

  // Register slave. Address and data are held until both have arrived.
  assign axi_awready_out = !aw_hold_q;
  assign axi_wready_out = !w_hold_q;
  assign axi_arready_out = !rvalid_q;
  assign wr_en = aw_hold_q && w_hold_q && !bvalid_q;
  assign axi_bvalid_out = bvalid_q;
  assign axi_bresp_out = bresp_q;
  assign axi_rvalid_out = rvalid_q;
  assign axi_rdata_out = rdata_q;
  assign axi_rresp_out = rresp_q;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{wstrb_q[i]}};
    end
    wr_hit = (awaddr_q == tdsp_pkg::ADDR_CTRL) || (awaddr_q == tdsp_pkg::ADDR_STATUS) ||
             (awaddr_q == tdsp_pkg::ADDR_TXDATA) || (awaddr_q == tdsp_pkg::ADDR_TIMING);
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= tdsp_pkg::RESP_OKAY;
    end else begin
      if (axi_awvalid_in && !aw_hold_q) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= axi_awaddr_in;
      end
      if (axi_wvalid_in && !w_hold_q) begin
        w_hold_q <= 1'b1;
        wdata_q <= axi_wdata_in;
        wstrb_q <= axi_wstrb_in;
      end
      if (wr_en) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? tdsp_pkg::RESP_OKAY : tdsp_pkg::RESP_SLVERR;
      end else if (bvalid_q && axi_bready_in) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign go = wr_en && (awaddr_q == tdsp_pkg::ADDR_CTRL) && wstrb_q[0] &&
              wdata_q[tdsp_pkg::CTRL_GO];

  // Configuration and message registers; strobes pick the bytes written.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cfg_q.rx_en <= 1'b0;
      cfg_q.majority <= 1'b0;
      cfg_q.bit_inc <= tdsp_pkg::BIT_INC_RST;
      cfg_q.sample_interval <= tdsp_pkg::SAMPLE_RST;
      txdata_q <= 32'h0000_0000;
    end else if (wr_en) begin
      if (awaddr_q == tdsp_pkg::ADDR_CTRL && wstrb_q[0]) begin
        cfg_q.rx_en <= wdata_q[tdsp_pkg::CTRL_RXEN];
        cfg_q.majority <= wdata_q[tdsp_pkg::CTRL_MAJ];
      end else if (awaddr_q == tdsp_pkg::ADDR_TXDATA) begin
        txdata_q <= (txdata_q & ~wmask) | (wdata_q & wmask);
      end else if (awaddr_q == tdsp_pkg::ADDR_TIMING) begin
        {cfg_q.sample_interval, cfg_q.bit_inc} <=
          ({cfg_q.sample_interval, cfg_q.bit_inc} & ~wmask) | (wdata_q & wmask);
      end
    end
  end

  // Transmitter.
  logic [tdsp_pkg::MAX_SHIFT-1:0] tx_shift_word_q; // RL7
  logic [4:0] tx_cnt_q;
  logic [1:0] tx_idx_q;
  logic [15:0] tx_cmp_q;
  logic tx_match;
  logic [tdsp_pkg::DATA_BITS-1:0] tx_next_data;

  assign tx_match = tick && (timer_q == tx_cmp_q);
  assign tx_next_data = txdata_q[{tx_idx_q + 2'h1, 3'h0} +: tdsp_pkg::DATA_BITS];

  // Right-justified shift word: data, odd parity, stop bit. // RL1 RL2 RL9
  function automatic logic [tdsp_pkg::MAX_SHIFT-1:0] tx_frame(
    input logic [tdsp_pkg::DATA_BITS-1:0] data
  );
    tx_frame = {{(tdsp_pkg::MAX_SHIFT - tdsp_pkg::DATA_BITS - 2){1'b0}}, 1'b1, ~^data, data};
  endfunction

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tx_state_q <= tdsp_pkg::TX_IDLE;
      tx_pin_out <= 1'b1;
      tx_shift_word_q <= 16'h0000;
      tx_cnt_q <= 5'h00;
      tx_idx_q <= 2'h0;
      tx_cmp_q <= 16'h0000;
    end else begin
      case (tx_state_q)
        tdsp_pkg::TX_IDLE: begin
          tx_pin_out <= 1'b1; // RL23
          if (go) begin
            tx_shift_word_q <= tx_frame(txdata_q[tdsp_pkg::DATA_BITS-1:0]);
            tx_cnt_q <= tdsp_pkg::SHIFT_CYCLES;
            tx_idx_q <= 2'h0;
            tx_pin_out <= 1'b0; // RL3
            tx_cmp_q <= timer_q + cfg_q.bit_inc; // RL4
            tx_state_q <= tdsp_pkg::TX_SHIFT;
          end
        end
        tdsp_pkg::TX_SHIFT: begin
          if (tx_match) begin
            tx_pin_out <= tx_shift_word_q[0]; // RL5 RL6 RL9
            tx_shift_word_q <= tx_shift_word_q >> 1;
            tx_cnt_q <= tx_cnt_q - 5'h01;
            tx_cmp_q <= tx_cmp_q + cfg_q.bit_inc;
            if (tx_cnt_q == 5'h01) begin
              tx_state_q <= tdsp_pkg::TX_DONE; // RL8
            end
          end
        end
        tdsp_pkg::TX_DONE: begin
          // The completion event lands one bit period after the stop bit went out.
          if (tx_match) begin // RL10
            if (tx_idx_q == 2'(tdsp_pkg::MSG_BYTES - 1)) begin // RL12
              tx_state_q <= tdsp_pkg::TX_IDLE;
              tx_pin_out <= 1'b1;
            end else begin
              tx_idx_q <= tx_idx_q + 2'h1;
              tx_shift_word_q <= tx_frame(tx_next_data); // RL11
              tx_cnt_q <= tdsp_pkg::SHIFT_CYCLES;
              tx_pin_out <= 1'b0;
              tx_cmp_q <= tx_cmp_q + cfg_q.bit_inc;
              tx_state_q <= tdsp_pkg::TX_SHIFT;
            end
          end
        end
        default: tx_state_q <= tdsp_pkg::TX_IDLE;
      endcase
    end
  end

  // Receiver. The first stage only feeds the second.
  logic rx_meta_q;
  logic rx_sync_q;
  logic rx_prev_q;
  logic rx_fall;
  logic [15:0] rx_channel_time_q;
  logic [8:0] rx_shift_word_q;
  logic [8:0] rx_word_next;
  logic [4:0] rx_cnt_q;
  logic [15:0] rx_samp_q;
  logic rx_first_q;
  logic rx_match;
  logic rx_shift;
  logic rx_bit;
  logic rx_complete;
  logic [1:0] rx_idx_q;
  logic perr_q;
  logic ferr_q;
  logic rxdone_q;
  logic perr_clr;
  logic ferr_clr;
  logic done_clr;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      rx_meta_q <= rx_pin_in;
      rx_sync_q <= rx_meta_q;
      rx_prev_q <= rx_sync_q;
    end
  end

  assign rx_fall = rx_prev_q && !rx_sync_q;
  assign rx_match = tick && (timer_q == rx_channel_time_q);
  assign rx_word_next = {rx_bit, rx_shift_word_q[8:1]};
  assign rx_complete = rx_shift && (rx_cnt_q == 5'h01);

  // Sample decision per bit, with an optional majority vote. // RL15 RL16 RL17
  always_comb begin
    rx_shift = 1'b0;
    rx_bit = rx_sync_q;
    case (rx_state_q)
      tdsp_pkg::RX_COMPARE: rx_shift = rx_match && !cfg_q.majority;
      tdsp_pkg::RX_MAJ2: begin
        rx_shift = tick && (rx_samp_q == 16'h0000) && (rx_sync_q == rx_first_q);
        rx_bit = rx_first_q;
      end
      tdsp_pkg::RX_MAJ3: rx_shift = tick && (rx_samp_q == 16'h0000);
      default: rx_shift = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rx_state_q <= tdsp_pkg::RX_CAPTURE;
      rx_channel_time_q <= 16'h0000;
      rx_shift_word_q <= 9'h000;
      rx_cnt_q <= 5'h00;
      rx_samp_q <= 16'h0000;
      rx_first_q <= 1'b0;
    end else begin
      case (rx_state_q)
        tdsp_pkg::RX_CAPTURE: begin
          if (cfg_q.rx_en && rx_fall) begin // RL13 RL19
            rx_channel_time_q <= timer_q + cfg_q.bit_inc + (cfg_q.bit_inc >> 1); // RL14
            rx_cnt_q <= tdsp_pkg::SHIFT_CYCLES; // RL18
            rx_state_q <= tdsp_pkg::RX_COMPARE;
          end
        end
        tdsp_pkg::RX_COMPARE: begin
          if (rx_match) begin
            rx_channel_time_q <= rx_channel_time_q + cfg_q.bit_inc; // RL15
            if (cfg_q.majority) begin
              rx_first_q <= rx_sync_q;
              rx_samp_q <= cfg_q.sample_interval;
              rx_state_q <= tdsp_pkg::RX_MAJ2;
            end
          end
        end
        tdsp_pkg::RX_MAJ2: begin
          if (tick) begin
            rx_samp_q <= rx_samp_q - 16'h0001;
            if (rx_samp_q == 16'h0000) begin
              rx_samp_q <= cfg_q.sample_interval;
              rx_state_q <= (rx_sync_q == rx_first_q) ? tdsp_pkg::RX_COMPARE :
                            tdsp_pkg::RX_MAJ3; // RL16
            end
          end
        end
        tdsp_pkg::RX_MAJ3: begin
          if (tick) begin
            rx_samp_q <= rx_samp_q - 16'h0001;
            if (rx_samp_q == 16'h0000) begin
              rx_state_q <= tdsp_pkg::RX_COMPARE;
            end
          end
        end
        default: rx_state_q <= tdsp_pkg::RX_CAPTURE;
      endcase
      if (rx_shift) begin
        rx_shift_word_q <= rx_word_next;
        rx_cnt_q <= rx_cnt_q - 5'h01;
      end
      if (rx_complete) begin
        rx_state_q <= tdsp_pkg::RX_CAPTURE; // RL21
      end
    end
  end

  assign perr_clr = wr_en && awaddr_q == tdsp_pkg::ADDR_STATUS && wdata_q[tdsp_pkg::ST_PERR];
  assign ferr_clr = wr_en && awaddr_q == tdsp_pkg::ADDR_STATUS && wdata_q[tdsp_pkg::ST_FERR];
  assign done_clr = wr_en && awaddr_q == tdsp_pkg::ADDR_STATUS && wdata_q[tdsp_pkg::ST_RXDONE];

  // Store and check each character; a new error wins over a clear. // RL20 RL22
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rxdata_q <= 32'h0000_0000;
      rx_idx_q <= 2'h0;
      perr_q <= 1'b0;
      ferr_q <= 1'b0;
      rxdone_q <= 1'b0;
    end else begin
      perr_q <= (perr_q && !perr_clr) || (rx_complete && !(^rx_word_next[7:0]));
      ferr_q <= (ferr_q && !ferr_clr) || (rx_complete && !rx_word_next[8]);
      rxdone_q <= (rxdone_q && !done_clr) ||
                  (rx_complete && rx_idx_q == 2'(tdsp_pkg::MSG_BYTES - 1));
      if (rx_complete) begin
        rxdata_q[{rx_idx_q, 3'h0} +: 8] <= rx_word_next[7:0];
        rx_idx_q <= rx_idx_q + 2'h1;
      end
    end
  end

  // Read path; unmapped addresses answer SLVERR with zero data.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= tdsp_pkg::RESP_OKAY;
    end else if (axi_arvalid_in && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q <= tdsp_pkg::RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      if (axi_araddr_in == tdsp_pkg::ADDR_CTRL) begin
        rdata_q[tdsp_pkg::CTRL_RXEN] <= cfg_q.rx_en;
        rdata_q[tdsp_pkg::CTRL_MAJ] <= cfg_q.majority;
      end else if (axi_araddr_in == tdsp_pkg::ADDR_STATUS) begin
        rdata_q[tdsp_pkg::ST_TXBUSY] <= tx_state_q != tdsp_pkg::TX_IDLE;
        rdata_q[tdsp_pkg::ST_RXBUSY] <= rx_state_q != tdsp_pkg::RX_CAPTURE;
        rdata_q[tdsp_pkg::ST_PERR] <= perr_q;
        rdata_q[tdsp_pkg::ST_FERR] <= ferr_q;
        rdata_q[tdsp_pkg::ST_RXDONE] <= rxdone_q;
        rdata_q[tdsp_pkg::ST_RXCNT +: 2] <= rx_idx_q;
      end else if (axi_araddr_in == tdsp_pkg::ADDR_TXDATA) begin
        rdata_q <= txdata_q;
      end else if (axi_araddr_in == tdsp_pkg::ADDR_RXDATA) begin
        rdata_q <= rxdata_q;
      end else if (axi_araddr_in == tdsp_pkg::ADDR_TIMING) begin
        rdata_q <= {cfg_q.sample_interval, cfg_q.bit_inc};
      end else begin
        rresp_q <= tdsp_pkg::RESP_SLVERR;
      end
    end else if (rvalid_q && axi_rready_in) begin
      rvalid_q <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  sequence tx_start_s;
    tx_state_q == tdsp_pkg::TX_IDLE && go;
  endsequence

  sequence tx_last_shift_s;
    tx_state_q == tdsp_pkg::TX_SHIFT && tx_match && tx_cnt_q == 5'h01;
  endsequence

  tick_period_a: assert property (tick |=> !tick [*3] ##1 tick) // RL4
    else $error("Bit time counter tick spacing wrong.");
  tx_idle_high_a: assert property ($past(tx_state_q) == tdsp_pkg::TX_IDLE && // RL23
    tx_state_q == tdsp_pkg::TX_IDLE |-> tx_pin_out)
    else $error("Transmit line not high while idle.");
  tx_start_low_a: assert property (tx_start_s |=> !tx_pin_out && // RL3
    tx_cnt_q == tdsp_pkg::SHIFT_CYCLES)
    else $error("Start bit not driven low.");
  tx_shift_bit_a: assert property (tx_state_q == tdsp_pkg::TX_SHIFT && tx_match // RL5
    |=> tx_pin_out == $past(tx_shift_word_q[0]))
    else $error("Transmit pin did not take the next shift bit.");
  tx_stop_high_a: assert property (tx_last_shift_s |=> tx_pin_out && // RL6
    tx_state_q == tdsp_pkg::TX_DONE)
    else $error("Stop bit not high after last shift.");
  tx_reload_a: assert property (tx_state_q == tdsp_pkg::TX_DONE && tx_match && // RL11
    tx_idx_q != 2'h3 |=> !tx_pin_out && tx_cnt_q == 5'h09 && tx_state_q == tdsp_pkg::TX_SHIFT)
    else $error("Character reload sequence wrong.");
  rx_first_cmp_a: assert property (rx_state_q == tdsp_pkg::RX_CAPTURE && cfg_q.rx_en && // RL14
    rx_fall |=> rx_state_q == tdsp_pkg::RX_COMPARE && rx_channel_time_q ==
    $past(timer_q) + $past(cfg_q.bit_inc) + ($past(cfg_q.bit_inc) >> 1))
    else $error("First receive compare not 1.5 bit periods out.");
  rx_rearm_a: assert property (rx_complete |=> rx_state_q == tdsp_pkg::RX_CAPTURE) // RL21
    else $error("Receiver did not return to capture.");
  rx_parity_a: assert property (rx_complete && !(^rx_word_next[7:0]) |=> perr_q) // RL20
    else $error("Parity error not flagged.");
endmodule

/* File: testbench/tdsp_host_model.sv */
/*
  Behavioural model of the host serial port that faces the serial pins.
  Assumes the bench calls send_char just after a rising clock edge.
*/
`timescale 1ns/1ps
module tdsp_host_model #(
  parameter int BIT_CLK = 64
) (
  // Clock.
  input wire logic clk_in,
  // Serial lines.
  input wire logic tx_line_in,
  output logic rx_line_out
);
  logic [9:0] rx_frames_q[$];
  realtime start_q[$];
  logic [9:0] shift_v;

  initial rx_line_out = 1'b1;
  // Sampling in mid-bit tolerates the one-tick jitter between bit edges.
  initial begin
    forever begin
      @(negedge tx_line_in);
      start_q.push_back($realtime);
      repeat (BIT_CLK / 2) @(posedge clk_in);
      for (int i = 0; i < 10; i++) begin
        shift_v[i] = tx_line_in;
        if (i < 9) repeat (BIT_CLK) @(posedge clk_in);
      end
      rx_frames_q.push_back(shift_v);
    end
  end

  task automatic send_char(input logic [6:0] data, input logic par_flip, input logic stop_bit);
    logic [9:0] fr;
    fr = {stop_bit, (~^data) ^ par_flip, data, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_line_out <= fr[i];
      repeat (BIT_CLK) @(posedge clk_in);
    end
    rx_line_out <= 1'b1;
    repeat (BIT_CLK) @(posedge clk_in);
  endtask
endmodule

/* File: testbench/tb_timer_driven_async_serial_port.sv */
/*
  Self-checking bench for the timer-driven serial port.
  Assumes the host model on the pins and a shortened bit time set via the timing register.
*/
`timescale 1ns/1ps
module tb_timer_driven_async_serial_port;
  logic clk_in, reset_in, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, rx_line, tx_line;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v, tx_word, rx_word;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp_v;
  logic [6:0] c;
  logic [9:0] frame_v;
  realtime gap;
  int err_total, cmp_count;

  tdsp_top dut (
    .clk_in(clk_in), .reset_in(reset_in), .axi_awvalid_in(awvalid),
    .axi_awready_out(awready), .axi_awaddr_in(awaddr), .axi_wvalid_in(wvalid),
    .axi_wready_out(wready), .axi_wdata_in(wdata), .axi_wstrb_in(wstrb),
    .axi_bvalid_out(bvalid), .axi_bready_in(bready), .axi_bresp_out(bresp),
    .axi_arvalid_in(arvalid), .axi_arready_out(arready), .axi_araddr_in(araddr),
    .axi_rvalid_out(rvalid), .axi_rready_in(rready), .axi_rdata_out(rdata),
    .axi_rresp_out(rresp), .rx_pin_in(rx_line), .tx_pin_out(tx_line)
  );
  tdsp_host_model #(.BIT_CLK(64)) host (
    .clk_in(clk_in), .tx_line_in(tx_line), .rx_line_out(rx_line)
  );

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic complete_run();
    $display("Mismatches %0d of %0d comparisons", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_left, w_left;
    aw_left = 1'b1;
    w_left = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw_left || w_left) begin
      @(posedge clk_in);
      if (aw_left && awready === 1'b1) begin
        aw_left = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_left && wready === 1'b1) begin
        w_left = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk_in); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    // Let one edge pass so a following call never re-raises bready in this step.
    @(posedge clk_in);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_in); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_in); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    // Let one edge pass so a following call never re-raises rready in this step.
    @(posedge clk_in);
  endtask

  task automatic reg_check(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    axi_read(a, rd_v, resp_v);
    check(rd_v, exp);
    check(32'(resp_v), 32'(er));
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    axi_write(a, d, resp_v);
    check(32'(resp_v), 32'(er));
  endtask

  // Sends four characters; bad_par and bad_stop pick which ones break the frame.
  task automatic rx_message(input logic [3:0] bad_par, input logic [3:0] bad_stop);
    for (int n = 0; n < 4; n++) begin
      c = 7'($urandom);
      rx_word[8*n +: 8] = {(~^c) ^ bad_par[n], c};
      host.send_char(c, bad_par[n], ~bad_stop[n]);
    end
  endtask

  initial begin
    repeat (30000) @(posedge clk_in);
    err_total++;
    complete_run();
  end

  initial begin
    void'($urandom(42530));
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    reset_in = 1'b1;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    check(32'(tx_line), 32'h1);
    reg_check(tdsp_pkg::ADDR_STATUS, 32'h0, tdsp_pkg::RESP_OKAY);
    rd_v = 32'(tdsp_pkg::CRYSTAL_HZ / (4 * tdsp_pkg::BAUD * tdsp_pkg::PRESCALE));
    reg_check(tdsp_pkg::ADDR_TIMING, {16'h0064, rd_v[15:0]}, tdsp_pkg::RESP_OKAY);
    reg_check(8'h14, 32'h0, tdsp_pkg::RESP_SLVERR);
    reg_write(8'h14, 32'hFFFF_FFFF, tdsp_pkg::RESP_SLVERR);
    reg_write(tdsp_pkg::ADDR_TIMING, 32'h0001_0010, tdsp_pkg::RESP_OKAY);
    tx_word = $urandom() & 32'h7F7F_7F7F;
    reg_write(tdsp_pkg::ADDR_TXDATA, tx_word, tdsp_pkg::RESP_OKAY);
    reg_write(tdsp_pkg::ADDR_CTRL, 32'h0000_0003, tdsp_pkg::RESP_OKAY);
    check(32'(tx_line), 32'h0);
    reg_check(tdsp_pkg::ADDR_STATUS, 32'h1, tdsp_pkg::RESP_OKAY);
    // A second start while busy must not restart or lengthen the message.
    reg_write(tdsp_pkg::ADDR_CTRL, 32'h0000_0003, tdsp_pkg::RESP_OKAY);
    repeat (41 * 64) @(posedge clk_in);
    check(32'(host.rx_frames_q.size()), 32'h4);
    for (int n = 0; n < 4; n++) begin
      c = tx_word[8*n +: 7];
      frame_v = (host.rx_frames_q.size() > 0) ? host.rx_frames_q.pop_front() : 10'h000;
      check(32'(frame_v), 32'({1'b1, ~^c, c, 1'b0}));
      if (n > 0 && host.start_q.size() > n) begin
        gap = host.start_q[n] - host.start_q[n-1];
        check(32'(gap >= 6360.0 && gap <= 6440.0), 32'h1);
      end
    end
    reg_check(tdsp_pkg::ADDR_STATUS, 32'h0, tdsp_pkg::RESP_OKAY);
    check(32'(tx_line), 32'h1);
    rx_message(4'b0000, 4'b0000);
    reg_check(tdsp_pkg::ADDR_RXDATA, rx_word, tdsp_pkg::RESP_OKAY);
    reg_check(tdsp_pkg::ADDR_STATUS, 32'h10, tdsp_pkg::RESP_OKAY);
    reg_write(tdsp_pkg::ADDR_STATUS, 32'h0000_001C, tdsp_pkg::RESP_OKAY);
    reg_check(tdsp_pkg::ADDR_STATUS, 32'h0, tdsp_pkg::RESP_OKAY);
    reg_write(tdsp_pkg::ADDR_CTRL, 32'h0000_0006, tdsp_pkg::RESP_OKAY);
    rx_message(4'b0010, 4'b0100);
    reg_check(tdsp_pkg::ADDR_RXDATA, rx_word, tdsp_pkg::RESP_OKAY);
    reg_check(tdsp_pkg::ADDR_STATUS, 32'h1C, tdsp_pkg::RESP_OKAY);
    complete_run();
  end
endmodule
